// [logic/ppm_pkg.sv]
// constants and carrier types of the port pin function multiplexer
// assumes one 20 MHz system clock; register bus with 8-bit address, 32-bit data
package ppm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PIN_N = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ST_W = 2;

  // ----------------------------------------------------------------
  // pin index inside every 7-bit pin vector
  // ----------------------------------------------------------------
  localparam int IDX_PORT_A_PIN_ZERO = 0;
  localparam int IDX_PORT_B_PIN_TWO = 1;
  localparam int IDX_PORT_B_PIN_THREE = 2;
  localparam int IDX_PORT_B_PIN_FOUR = 3;
  localparam int IDX_PORT_B_PIN_FIVE = 4;
  localparam int IDX_PORT_B_PIN_SIX = 5;
  localparam int IDX_PORT_B_PIN_SEVEN = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PULL_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PULL_LOW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DIN_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ALT_GEN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ALT_TMR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CFG = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STRAP = 8'h2c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLD_COMP_LSB = 0;
  localparam int FLD_GEN_A_LSB = 8;
  localparam int FLD_GEN_B_LSB = 16;
  localparam int FLD_GEN_C_LSB = 24;
  localparam int FLD_TM3_LSB = 0;
  localparam int FLD_TM2_LSB = 8;
  localparam int FLD_EDGE_LSB = 0;
  localparam int ST_EXT_IRQ = 0;
  localparam int ST_WAKE = 1;

  // ----------------------------------------------------------------
  // pins on which each function exists
  // ----------------------------------------------------------------
  localparam logic [PIN_N-1:0] LEGAL_PULL_LOW = 7'h06;
  localparam logic [PIN_N-1:0] LEGAL_COMP = 7'h01;
  localparam logic [PIN_N-1:0] LEGAL_GEN_A = 7'h39;
  localparam logic [PIN_N-1:0] LEGAL_GEN_B = 7'h60;
  localparam logic [PIN_N-1:0] LEGAL_GEN_C = 7'h16;
  localparam logic [PIN_N-1:0] LEGAL_TM3 = 7'h70;
  localparam logic [PIN_N-1:0] LEGAL_TM2 = 7'h0a;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [PIN_N-1:0] RST_PINS_ZERO = 7'h00;
  localparam logic [PIN_N-1:0] RST_DIN_EN = 7'h7f;
  localparam logic [ST_W-1:0] RST_STATUS = 2'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EDGE_BOTH, EDGE_RISE, EDGE_FALL} ppm_edge_t;

  typedef struct packed {
    logic comparator_out;
    logic gen_a_pwm_out;
    logic gen_b_pwm_out;
    logic gen_c_pwm_out;
    logic timer_two_pwm_out;
    logic timer_three_pwm_out;
  } ppm_alt_src_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ppm_bus_req_t;

endpackage

// [logic/ppm_sync2.sv]
// two flip-flop synchroniser for levels from outside the clock domain
// assumes asynchronous active-high reset; first stage feeds only the second
`timescale 1ns/1ps
module ppm_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

// [logic/ppm_port_mux.sv]
// port pin function multiplexer: port a pin zero and port b pins two to seven
// assumes pads resolved outside; alternate sources come from logic on I_CLK_SYS
//
// What this block does
// - each pin: digital input or push-pull output
// - pull-low only on b two/three; pull-high everywhere
// - cleared input-enable blocks the pin read path
// - cleared input-enable blocks wake from power-down
// - a0 or b5 is ext irq zero, edge selectable
// - comparator output can drive pin a0
// - generator a routes to a0, b4, b5, b6
// - generator b routes to b6, b7
// - generator c routes to b2, b3, b5
// - timer three b5-b7, timer two b2, b4
// - irq pin choice fixed by strap option
`timescale 1ns/1ps
module ppm_port_mux
  import ppm_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire ppm_bus_req_t I_BUS_REQ,
  output logic [DATA_W-1:0] O_RDATA,
  input wire ppm_alt_src_t I_ALT_SRC,
  input wire logic I_SLEEP,
  input wire logic I_IRQ_PIN_STRAP,
  input wire logic [PIN_N-1:0] I_PAD_IN,
  output logic [PIN_N-1:0] O_PAD_OUT,
  output logic [PIN_N-1:0] O_PAD_OE_N,
  output logic [PIN_N-1:0] O_PULL_HIGH,
  output logic [PIN_N-1:0] O_PULL_LOW,
  output logic O_EXT_IRQ_LINE_ZERO,
  output logic O_WAKE_REQ,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] data_reg;
  logic [PIN_N-1:0] dir_reg;
  logic [PIN_N-1:0] din_en_reg;
  logic [PIN_N-1:0] comp_en_reg;
  logic [PIN_N-1:0] gen_a_en_reg;
  logic [PIN_N-1:0] gen_b_en_reg;
  logic [PIN_N-1:0] gen_c_en_reg;
  logic [PIN_N-1:0] tm3_en_reg;
  logic [PIN_N-1:0] tm2_en_reg;
  logic [1:0] edge_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [PIN_N-1:0] pin_prev_reg;
  logic [1:0] settle_reg;
  logic strap_done_reg;
  logic strap_sel_reg;
  logic [ST_W-1:0] status_next;
  logic [DATA_W-1:0] rdata_next;
  logic [PIN_N:0] sync_q;
  logic [PIN_N-1:0] pin_sync;
  logic strap_sync;
  logic [PIN_N-1:0] pin_level;
  logic [PIN_N-1:0] rise_vec;
  logic [PIN_N-1:0] fall_vec;
  logic [PIN_N-1:0] alt_any;
  logic [PIN_N-1:0] alt_val;
  logic [PIN_N-1:0] pad_out_next;
  logic [PIN_N-1:0] pad_oe_n_next;
  logic sel_rise;
  logic sel_fall;
  logic ext_irq_ev;
  logic wake_ev;
  ppm_edge_t edge_mode;

  wire wr_data = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_DATA);
  wire wr_dir = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_DIR);
  wire wr_pull_high = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_PULL_HIGH);
  wire wr_pull_low = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_PULL_LOW);
  wire wr_din_en = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_DIN_EN);
  wire wr_alt_gen = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_ALT_GEN);
  wire wr_alt_tmr = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_ALT_TMR);
  wire wr_irq_cfg = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_IRQ_CFG);
  wire wr_status = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_STATUS);
  wire wr_mask = I_BUS_REQ.wr && (I_BUS_REQ.addr == OFS_MASK);
  wire [PIN_N-1:0] wdata_pins = I_BUS_REQ.wdata[PIN_N-1:0];

  // ----------------------------------------------------------------
  // pad and strap synchronisers
  // ----------------------------------------------------------------
  ppm_sync2 #(
    .W(PIN_N + 1)
  ) u_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_async({I_IRQ_PIN_STRAP, I_PAD_IN}),
    .o_sync(sync_q)
  );

  assign pin_sync = sync_q[PIN_N-1:0];
  assign strap_sync = sync_q[PIN_N];

  // ----------------------------------------------------------------
  // input path gating and edge detection
  // ----------------------------------------------------------------
  assign pin_level = pin_sync & din_en_reg;
  assign rise_vec = pin_sync & ~pin_prev_reg & din_en_reg;
  assign fall_vec = ~pin_sync & pin_prev_reg & din_en_reg;
  assign wake_ev = I_SLEEP && |(rise_vec | fall_vec);

  // irq pin picked by the captured strap, not by software
  assign sel_rise = strap_sel_reg ? rise_vec[IDX_PORT_B_PIN_FIVE] : rise_vec[IDX_PORT_A_PIN_ZERO];
  assign sel_fall = strap_sel_reg ? fall_vec[IDX_PORT_B_PIN_FIVE] : fall_vec[IDX_PORT_A_PIN_ZERO];
  assign edge_mode = ppm_edge_t'(edge_reg);

  always_comb begin
    case (edge_mode)
      EDGE_BOTH: ext_irq_ev = strap_done_reg && (sel_rise || sel_fall);
      EDGE_RISE: ext_irq_ev = strap_done_reg && sel_rise;
      EDGE_FALL: ext_irq_ev = strap_done_reg && sel_fall;
      default: ext_irq_ev = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // output multiplexer, one slice per pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      // comparator, gen a, gen b, gen c, timer three, timer two, then port data
      assign alt_any[gi] = comp_en_reg[gi] | gen_a_en_reg[gi] | gen_b_en_reg[gi] |
                           gen_c_en_reg[gi] | tm3_en_reg[gi] | tm2_en_reg[gi];
      assign alt_val[gi] = comp_en_reg[gi] ? I_ALT_SRC.comparator_out :
                           gen_a_en_reg[gi] ? I_ALT_SRC.gen_a_pwm_out :
                           gen_b_en_reg[gi] ? I_ALT_SRC.gen_b_pwm_out :
                           gen_c_en_reg[gi] ? I_ALT_SRC.gen_c_pwm_out :
                           tm3_en_reg[gi] ? I_ALT_SRC.timer_three_pwm_out :
                           I_ALT_SRC.timer_two_pwm_out;
      assign pad_out_next[gi] = alt_any[gi] ? alt_val[gi] : data_reg[gi];
      assign pad_oe_n_next[gi] = ~(alt_any[gi] | dir_reg[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // status and read data
  // ----------------------------------------------------------------
  // a new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~(wr_status ? I_BUS_REQ.wdata[ST_W-1:0] : RST_STATUS)) |
                       {wake_ev, ext_irq_ev};

  always_comb begin
    rdata_next = '0;
    if (I_BUS_REQ.rd) begin
      case (I_BUS_REQ.addr)
        OFS_DATA: rdata_next[PIN_N-1:0] = data_reg;
        OFS_DIR: rdata_next[PIN_N-1:0] = dir_reg;
        OFS_PULL_HIGH: rdata_next[PIN_N-1:0] = O_PULL_HIGH;
        OFS_PULL_LOW: rdata_next[PIN_N-1:0] = O_PULL_LOW;
        OFS_DIN_EN: rdata_next[PIN_N-1:0] = din_en_reg;
        OFS_PIN_LEVEL: rdata_next[PIN_N-1:0] = pin_level;
        OFS_ALT_GEN: begin
          rdata_next[FLD_COMP_LSB +: PIN_N] = comp_en_reg;
          rdata_next[FLD_GEN_A_LSB +: PIN_N] = gen_a_en_reg;
          rdata_next[FLD_GEN_B_LSB +: PIN_N] = gen_b_en_reg;
          rdata_next[FLD_GEN_C_LSB +: PIN_N] = gen_c_en_reg;
        end
        OFS_ALT_TMR: begin
          rdata_next[FLD_TM3_LSB +: PIN_N] = tm3_en_reg;
          rdata_next[FLD_TM2_LSB +: PIN_N] = tm2_en_reg;
        end
        OFS_IRQ_CFG: rdata_next[FLD_EDGE_LSB +: 2] = edge_reg;
        OFS_STATUS: rdata_next[ST_W-1:0] = status_reg;
        OFS_MASK: rdata_next[ST_W-1:0] = mask_reg;
        OFS_STRAP: rdata_next[1:0] = {strap_done_reg, strap_sel_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      data_reg <= RST_PINS_ZERO;
      dir_reg <= RST_PINS_ZERO;
      din_en_reg <= RST_DIN_EN;
      edge_reg <= 2'h0;
      mask_reg <= RST_STATUS;
    end else begin
      if (wr_data) data_reg <= wdata_pins;
      if (wr_dir) dir_reg <= wdata_pins;
      if (wr_din_en) din_en_reg <= wdata_pins;
      if (wr_irq_cfg) edge_reg <= I_BUS_REQ.wdata[FLD_EDGE_LSB +: 2];
      if (wr_mask) mask_reg <= I_BUS_REQ.wdata[ST_W-1:0];
    end
  end

  // pull-high and pull-low never both on one pin
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_PULL_HIGH <= RST_PINS_ZERO;
      O_PULL_LOW <= RST_PINS_ZERO;
    end else if (wr_pull_high) begin
      O_PULL_HIGH <= wdata_pins;
      O_PULL_LOW <= O_PULL_LOW & ~wdata_pins;
    end else if (wr_pull_low) begin
      O_PULL_LOW <= wdata_pins & LEGAL_PULL_LOW & ~O_PULL_HIGH;
    end
  end

  // enables only stick on pins where the function exists
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      comp_en_reg <= RST_PINS_ZERO;
      gen_a_en_reg <= RST_PINS_ZERO;
      gen_b_en_reg <= RST_PINS_ZERO;
      gen_c_en_reg <= RST_PINS_ZERO;
      tm3_en_reg <= RST_PINS_ZERO;
      tm2_en_reg <= RST_PINS_ZERO;
    end else begin
      if (wr_alt_gen) begin
        comp_en_reg <= I_BUS_REQ.wdata[FLD_COMP_LSB +: PIN_N] & LEGAL_COMP;
        gen_a_en_reg <= I_BUS_REQ.wdata[FLD_GEN_A_LSB +: PIN_N] & LEGAL_GEN_A;
        gen_b_en_reg <= I_BUS_REQ.wdata[FLD_GEN_B_LSB +: PIN_N] & LEGAL_GEN_B;
        gen_c_en_reg <= I_BUS_REQ.wdata[FLD_GEN_C_LSB +: PIN_N] & LEGAL_GEN_C;
      end
      if (wr_alt_tmr) begin
        tm3_en_reg <= I_BUS_REQ.wdata[FLD_TM3_LSB +: PIN_N] & LEGAL_TM3;
        tm2_en_reg <= I_BUS_REQ.wdata[FLD_TM2_LSB +: PIN_N] & LEGAL_TM2;
      end
    end
  end

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      settle_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_sel_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      if (settle_reg == STRAP_SETTLE) begin
        strap_sel_reg <= strap_sync;
        strap_done_reg <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pads, events and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pin_prev_reg <= RST_PINS_ZERO;
      status_reg <= RST_STATUS;
      O_PAD_OUT <= RST_PINS_ZERO;
      O_PAD_OE_N <= RST_DIN_EN;
      O_RDATA <= '0;
      O_EXT_IRQ_LINE_ZERO <= 1'b0;
      O_WAKE_REQ <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
      status_reg <= status_next;
      O_PAD_OUT <= pad_out_next;
      O_PAD_OE_N <= pad_oe_n_next;
      O_RDATA <= rdata_next;
      O_EXT_IRQ_LINE_ZERO <= ext_irq_ev;
      O_WAKE_REQ <= wake_ev;
      O_IRQ <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  sequence s_plain_output(int i);
    dir_reg[i] && !alt_any[i];
  endsequence

  sequence s_pin_rises_on(int i);
    din_en_reg[i] && pin_sync[i] && !pin_prev_reg[i];
  endsequence

  a_output_follows_data: assert property (
    s_plain_output(IDX_PORT_B_PIN_THREE) |=> !O_PAD_OE_N[IDX_PORT_B_PIN_THREE] &&
      O_PAD_OUT[IDX_PORT_B_PIN_THREE] == $past(data_reg[IDX_PORT_B_PIN_THREE]))
    else $error("plain output pin does not follow its data bit");

  a_input_released: assert property (
    (dir_reg == 7'h00 && alt_any == 7'h00) |=> O_PAD_OE_N == 7'h7f)
    else $error("input pins are being driven");

  a_pull_low_legal: assert property (
    (O_PULL_LOW & ~LEGAL_PULL_LOW) == 7'h00 && (O_PULL_LOW & O_PULL_HIGH) == 7'h00)
    else $error("pull-low on an illegal pin or with pull-high");

  a_read_gated: assert property (
    (I_BUS_REQ.rd && I_BUS_REQ.addr == OFS_PIN_LEVEL && !din_en_reg[IDX_PORT_B_PIN_SIX])
      |=> O_RDATA[IDX_PORT_B_PIN_SIX] == 1'b0)
    else $error("disabled pin leaks into pin read");

  a_wake_gated: assert property (
    $rose(O_WAKE_REQ) |-> $past(I_SLEEP) && $past(|((pin_sync ^ pin_prev_reg) & din_en_reg)))
    else $error("wake without an enabled pin toggle");

  a_irq_edge_rise: assert property (
    (strap_done_reg && !strap_sel_reg && edge_mode == EDGE_RISE) ##0 s_pin_rises_on(IDX_PORT_A_PIN_ZERO)
      |=> O_EXT_IRQ_LINE_ZERO && status_reg[ST_EXT_IRQ])
    else $error("rising edge on pin a0 missed");

  a_irq_edge_fall_only: assert property (
    (edge_mode == EDGE_FALL && sel_rise && !sel_fall) |=> !O_EXT_IRQ_LINE_ZERO)
    else $error("rising edge taken in falling mode");

  a_comp_wins_a0: assert property (
    comp_en_reg[IDX_PORT_A_PIN_ZERO] |=> O_PAD_OUT[IDX_PORT_A_PIN_ZERO] == $past(I_ALT_SRC.comparator_out))
    else $error("comparator does not own pin a0");

  a_gen_a_routes: assert property (
    (gen_a_en_reg & ~LEGAL_GEN_A) == 7'h00)
    else $error("generator a on an illegal pin");

  a_gen_b_routes: assert property (
    (gen_b_en_reg[IDX_PORT_B_PIN_SEVEN] && !tm3_en_reg[IDX_PORT_B_PIN_SEVEN])
      |=> O_PAD_OUT[IDX_PORT_B_PIN_SEVEN] == $past(I_ALT_SRC.gen_b_pwm_out))
    else $error("generator b not on pin b7");

  a_gen_c_routes: assert property (
    (gen_c_en_reg[IDX_PORT_B_PIN_THREE]) |=> O_PAD_OUT[IDX_PORT_B_PIN_THREE] == $past(I_ALT_SRC.gen_c_pwm_out))
    else $error("generator c not on pin b3");

  a_timer_routes: assert property (
    (tm2_en_reg[IDX_PORT_B_PIN_FOUR] && !gen_a_en_reg[IDX_PORT_B_PIN_FOUR])
      |=> O_PAD_OUT[IDX_PORT_B_PIN_FOUR] == $past(I_ALT_SRC.timer_two_pwm_out) && !O_PAD_OE_N[IDX_PORT_B_PIN_FOUR])
    else $error("timer two not on pin b4");

  a_strap_held: assert property (
    strap_done_reg |=> strap_done_reg && $stable(strap_sel_reg))
    else $error("irq pin choice changed after capture");

  a_priority_one_src: assert property (
    (gen_a_en_reg[IDX_PORT_B_PIN_FIVE] && gen_c_en_reg[IDX_PORT_B_PIN_FIVE])
      |=> O_PAD_OUT[IDX_PORT_B_PIN_FIVE] == $past(I_ALT_SRC.gen_a_pwm_out))
    else $error("lower source overrides generator a");

  a_irq_level: assert property (
    ##1 O_IRQ == |($past(status_next) & $past(mask_reg)))
    else $error("interrupt output does not follow masked status");

endmodule

// [verification/ppm_board.sv]
// board model: what hangs on the seven port pins
// assumes active-low output enables and one system clock
`timescale 1ns/1ps
module ppm_board
  import ppm_pkg::*;
(
  input wire logic i_clk,
  input wire logic [PIN_N-1:0] i_pad_out,
  input wire logic [PIN_N-1:0] i_oe_n,
  input wire logic [PIN_N-1:0] i_pull_high,
  input wire logic [PIN_N-1:0] i_pull_low,
  input wire logic [PIN_N-1:0] i_ext_en,
  input wire logic [PIN_N-1:0] i_ext_val,
  output logic [PIN_N-1:0] o_pad
);
  logic flt_reg = 1'b0;
  wire logic [PIN_N-1:0] drv = ~i_oe_n;
  wire logic [PIN_N-1:0] ext = i_oe_n & i_ext_en;
  wire logic [PIN_N-1:0] pulled = i_oe_n & ~i_ext_en & i_pull_high;
  wire logic [PIN_N-1:0] flt = i_oe_n & ~i_ext_en & ~i_pull_high & ~i_pull_low;
  // undriven pin without pull wanders every cycle
  always @(posedge i_clk) begin
    flt_reg <= ~flt_reg;
  end
  assign o_pad = (drv & i_pad_out) | (ext & i_ext_val) | pulled | (flt & {PIN_N{flt_reg}});
endmodule

// [verification/ppm_port_mux_tb_top.sv]
// self-checking bench for the port pin function multiplexer
// assumes the board model drives the pads; strap driven by the bench
`timescale 1ns/1ps
module ppm_port_mux_tb_top
  import ppm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ppm_bus_req_t req = '0;
  ppm_alt_src_t alt = '0;
  logic sleep = 1'b0;
  logic strap = 1'b0;
  logic [PIN_N-1:0] ext_en = 7'h7f;
  logic [PIN_N-1:0] ext_val = 7'h00;
  logic [PIN_N-1:0] pad_in, pad_out, oe_n, pu, pd;
  logic [DATA_W-1:0] rdata;
  logic irq_pulse, wake, irq;
  int n_errors = 0;
  int checks_done = 0;
  int n_ext = 0;
  int n_wake = 0;
  int cycles = 0;

  ppm_port_mux dut (.I_CLK_SYS(clk), .I_RST(rst), .I_BUS_REQ(req), .O_RDATA(rdata), .I_ALT_SRC(alt),
    .I_SLEEP(sleep), .I_IRQ_PIN_STRAP(strap), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE_N(oe_n),
    .O_PULL_HIGH(pu), .O_PULL_LOW(pd), .O_EXT_IRQ_LINE_ZERO(irq_pulse), .O_WAKE_REQ(wake), .O_IRQ(irq));
  ppm_board board (.i_clk(clk), .i_pad_out(pad_out), .i_oe_n(oe_n), .i_pull_high(pu), .i_pull_low(pd),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad_in));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // pulse counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (irq_pulse === 1'b1) n_ext++;
    if (wake === 1'b1) n_wake++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(OFS_DIN_EN, 32'h7f);
    rchk(OFS_DIR, 32'h0);
    chk(32'(oe_n), 32'h7f);
  endtask

  task automatic t_io;
    wr(OFS_DIR, 32'h7f);
    wr(OFS_DATA, 32'h5a);
    settle;
    chk(32'(pad_out), 32'h5a);
    chk(32'(oe_n), 32'h0);
    rchk(OFS_PIN_LEVEL, 32'h5a);
    wr(OFS_DIR, 32'h0);
    ext_val <= 7'h25;
    settle;
    chk(32'(oe_n), 32'h7f);
    rchk(OFS_PIN_LEVEL, 32'h25);
    // pins b5 to b7 treated as analog inputs
    wr(OFS_DIN_EN, 32'h0f);
    settle;
    rchk(OFS_PIN_LEVEL, 32'h05);
    wr(OFS_DIN_EN, 32'h7f);
    wr(OFS_DATA, 32'h0);
  endtask

  task automatic t_pull;
    wr(OFS_PULL_HIGH, 32'h79);
    wr(OFS_PULL_LOW, 32'h7f);
    ext_en <= 7'h00;
    settle;
    chk(32'(pu), 32'h79);
    chk(32'(pd), 32'h06);
    rchk(OFS_PULL_LOW, 32'h06);
    rchk(OFS_PIN_LEVEL, 32'h79);
    wr(OFS_PULL_HIGH, 32'h7b);
    settle;
    chk(32'(pd), 32'h04);
    rchk(OFS_PIN_LEVEL, 32'h7b);
    ext_en <= 7'h7f;
    wr(OFS_PULL_HIGH, 32'h0);
  endtask

  task automatic t_src(input logic [ADDR_W-1:0] ofs, input int lsb, input logic [PIN_N-1:0] legal, input int sbit);
    wr(ofs, 32'h7f << lsb);
    alt <= ppm_alt_src_t'(6'h01 << sbit);
    settle;
    rchk(ofs, 32'(legal) << lsb);
    chk(32'(pad_out), 32'(legal));
    chk(32'(oe_n ^ legal), 32'h7f);
    wr(ofs, 32'h0);
    alt <= '0;
  endtask

  task automatic t_prio;
    wr(OFS_ALT_GEN, 32'h0101);
    alt <= '{gen_a_pwm_out: 1'b1, default: 1'b0};
    settle;
    chk(32'(pad_out[0]), 32'h0);
    alt <= '{comparator_out: 1'b1, default: 1'b0};
    settle;
    chk(32'(pad_out[0]), 32'h1);
    chk(32'(oe_n[0]), 32'h0);
    // gen a and gen c both on pin b5
    wr(OFS_ALT_GEN, 32'h10001000);
    alt <= '{gen_c_pwm_out: 1'b1, default: 1'b0};
    settle;
    chk(32'(pad_out[4]), 32'h0);
    wr(OFS_ALT_GEN, 32'h0);
    alt <= '0;
  endtask

  task automatic t_irq;
    int n0;
    ext_val <= 7'h00;
    wr(OFS_IRQ_CFG, 32'h1);
    wr(OFS_MASK, 32'h1);
    settle;
    wr(OFS_STATUS, 32'h3);
    n0 = n_ext;
    ext_val <= 7'h01;
    settle;
    chk(32'(n_ext - n0), 32'h1);
    chk(32'(irq), 32'h1);
    rchk(OFS_STATUS, 32'h1);
    // a0 falls and b5 rises: neither counts
    ext_val <= 7'h10;
    settle;
    chk(32'(n_ext - n0), 32'h1);
    wr(OFS_STATUS, 32'h1);
    settle;
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_CFG, 32'h2);
    ext_val <= 7'h01;
    settle;
    ext_val <= 7'h00;
    settle;
    chk(32'(n_ext - n0), 32'h2);
    rchk(OFS_STRAP, 32'h2);
  endtask

  task automatic t_wake;
    int w0;
    int e0;
    wr(OFS_IRQ_CFG, 32'h0);
    wr(OFS_DIN_EN, 32'h7e);
    sleep <= 1'b1;
    w0 = n_wake;
    e0 = n_ext;
    ext_val <= 7'h01;
    settle;
    chk(32'(n_wake - w0), 32'h0);
    chk(32'(n_ext - e0), 32'h0);
    ext_val <= 7'h03;
    settle;
    chk(32'(n_wake - w0), 32'h1);
    sleep <= 1'b0;
  endtask

  task automatic t_strap;
    int e0;
    @(posedge clk);
    ext_val <= 7'h00;
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle;
    rchk(OFS_STRAP, 32'h3);
    e0 = n_ext;
    ext_val <= 7'h01;
    settle;
    chk(32'(n_ext - e0), 32'h0);
    ext_val <= 7'h11;
    settle;
    chk(32'(n_ext - e0), 32'h1);
    // edge mode none: b5 falling is ignored
    wr(OFS_IRQ_CFG, 32'h3);
    ext_val <= 7'h01;
    settle;
    chk(32'(n_ext - e0), 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_io;
    t_pull;
    t_src(OFS_ALT_GEN, FLD_COMP_LSB, 7'h01, 5);
    t_src(OFS_ALT_GEN, FLD_GEN_A_LSB, 7'h39, 4);
    t_src(OFS_ALT_GEN, FLD_GEN_B_LSB, 7'h60, 3);
    t_src(OFS_ALT_GEN, FLD_GEN_C_LSB, 7'h16, 2);
    t_src(OFS_ALT_TMR, FLD_TM2_LSB, 7'h0a, 1);
    t_src(OFS_ALT_TMR, FLD_TM3_LSB, 7'h70, 0);
    t_prio;
    t_irq;
    t_wake;
    t_strap;
    report_and_stop();
  end
endmodule
